// ===== ccr_pkg.sv
package ccr_pkg;

   // Register offsets on the serial management register port
   localparam logic [7:0] ADDR_INPUT_CURRENT = 8'h03;
   localparam logic [7:0] ADDR_PRECHG_TERM   = 8'h04;
   localparam logic [7:0] ADDR_CTRL_ONE      = 8'h05;
   localparam logic [7:0] ADDR_CTRL_TWO      = 8'h06;
   localparam logic [7:0] ADDR_WD_KICK       = 8'h07;

   // Reset values
   localparam logic [7:0] RST_INPUT_CURRENT = 8'h39;
   localparam logic [7:0] RST_PRECHG_TERM   = 8'h22;
   localparam logic [7:0] RST_CTRL_ONE      = 8'h9d;
   localparam logic [7:0] RST_CTRL_TWO      = 8'h7d;

   // Fields that return to default on watchdog expiry
   localparam logic [7:0] WDM_INPUT_CURRENT = 8'hc0;
   localparam logic [7:0] WDM_PRECHG_TERM   = 8'hff;
   localparam logic [7:0] WDM_CTRL_ONE      = 8'hff;
   localparam logic [7:0] WDM_CTRL_TWO      = 8'hfc;

   // Input current control fields
   localparam int FORCE_OPT_BIT = 7;
   localparam int FORCE_DET_BIT = 6;
   localparam int OPT_EN_BIT    = 5;
   localparam int CURRENT_LIMIT_PIN_LSB      = 0;
   localparam int CURRENT_LIMIT_PIN_W        = 5;
   // Precharge and termination fields
   localparam int PRECHG_LSB    = 4;
   localparam int TERM_LSB      = 0;
   localparam int CUR_W         = 4;
   // Control one fields
   localparam int TERM_EN_BIT   = 7;
   localparam int RSVD_BIT      = 6;
   localparam int WD_LSB        = 4;
   localparam int TIMER_EN_BIT  = 3;
   localparam int FCT_LSB       = 1;
   localparam int HALF_BIT      = 0;
   localparam int SEL_W         = 2;
   // Control two fields
   localparam int REVB_BIT      = 7;
   localparam int AUTO_DET_BIT  = 6;
   localparam int THERMAL_REG_THRESHOLD_LSB      = 4;
   localparam int CHG_EN_BIT    = 3;
   localparam int EXIT_BIT      = 2;
   localparam int RECHG_LSB     = 0;
   // Watchdog kick bit at the kick offset
   localparam int KICK_BIT      = 6;

   // Scaling of the analog settings
   localparam logic [4:0] CURRENT_LIMIT_PIN_MAX_CODE = 5'h1c;
   localparam int CURRENT_LIMIT_PIN_OFFSET_MA  = 500;
   localparam int CURRENT_LIMIT_PIN_STEP_MA    = 100;
   localparam int CUR_OFFSET_MA   = 50;
   localparam int CUR_STEP_MA     = 50;
   localparam int RECHG_OFFSET_MV = 100;
   localparam int RECHG_STEP_MV   = 100;
   localparam int EXIT_LOW_MV     = 5600;
   localparam int EXIT_HIGH_MV    = 6000;
   localparam int THERMAL_REG_THRESHOLD_00_C = 60;
   localparam int THERMAL_REG_THRESHOLD_01_C = 80;
   localparam int THERMAL_REG_THRESHOLD_10_C = 100;
   localparam int THERMAL_REG_THRESHOLD_11_C = 120;

   // Timing
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int WD_01_S  = 40;
   localparam int WD_10_S  = 80;
   localparam int WD_11_S  = 160;
   localparam int FCT_00_H = 5;
   localparam int FCT_01_H = 8;
   localparam int FCT_10_H = 12;
   localparam int FCT_11_H = 20;
   localparam int SEC_PER_HOUR = 3600;
   localparam int SEC_W = 17;

   // Decoded settings handed to the analog loops
   typedef struct packed {
      logic [11:0] current_limit_pin_ma;
      logic [9:0]  prechg_ma;
      logic [9:0]  term_ma;
      logic        term_en;
      logic        timer_en;
      logic        half_rate;
      logic [7:0]  thermal_reg_threshold_c;
      logic [12:0] exit_mv;
      logic [8:0]  rechg_mv;
      logic        charge_mode;
      logic        reverse_buck_mode;
      logic        optimizer_en;
      logic        auto_detect_en;
   } ccr_cfg_t;

   // Codes above the top step saturate at the top step
   function automatic logic [4:0] current_limit_pin_clamp(input logic [4:0] code);
      current_limit_pin_clamp = (code > CURRENT_LIMIT_PIN_MAX_CODE) ? CURRENT_LIMIT_PIN_MAX_CODE : code;
   endfunction : current_limit_pin_clamp

   // Watchdog period in seconds, zero when disabled
   function automatic logic [7:0] wd_seconds(input logic [1:0] sel);
      case (sel)
         2'h1:    wd_seconds = 8'(WD_01_S);
         2'h2:    wd_seconds = 8'(WD_10_S);
         2'h3:    wd_seconds = 8'(WD_11_S);
         default: wd_seconds = 8'h00;
      endcase
   endfunction : wd_seconds

   // Fast charge limit in seconds
   function automatic logic [SEC_W-1:0] fct_seconds(input logic [1:0] sel);
      case (sel)
         2'h0:    fct_seconds = SEC_W'(FCT_00_H * SEC_PER_HOUR);
         2'h1:    fct_seconds = SEC_W'(FCT_01_H * SEC_PER_HOUR);
         2'h2:    fct_seconds = SEC_W'(FCT_10_H * SEC_PER_HOUR);
         default: fct_seconds = SEC_W'(FCT_11_H * SEC_PER_HOUR);
      endcase
   endfunction : fct_seconds

endpackage : ccr_pkg

// ===== ccr_properties.sv
`timescale 1ns/1ps
module ccr_properties (
   input wire logic              clk_sys,               // System clock
   input wire logic              sys_rst,               // Async reset
   input wire logic [7:0]        reg_addr,              // Register offset
   input wire logic              reg_rd,                // Read strobe
   input wire logic [7:0]        reg_rdata,             // Read data
   input wire logic [4:0]        current_limit_pin,     // Pin limit code
   input wire logic              optimizer_force_start, // Optimizer pulse
   input wire logic              watchdog_expired,      // Expiry pulse
   input wire logic              source_detect_start,   // Detect pulse
   input wire ccr_pkg::ccr_cfg_t cfg                    // Decoded settings
);
   // One clock domain, so one default clock and reset for all checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   // Current, thermal and exit settings are checked from the second edge after reset; the other checks run from the first
   property p_rsvd; reg_rd && reg_addr == 8'h05 |=> reg_rdata[6] == 1'b0; endproperty
   property p_kick; reg_rd && reg_addr == 8'h07 |=> reg_rdata[6] == 1'b0; endproperty
   property p_current_limit_pin;
      current_limit_pin == $past(current_limit_pin) && current_limit_pin ==
         $past(current_limit_pin, 2) |-> cfg.current_limit_pin_ma <= 12'd3300 &&
         cfg.current_limit_pin_ma <= 12'd500 + 12'd100 * 12'(current_limit_pin);
   endproperty
   property p_rbuck; cfg.charge_mode |-> !cfg.reverse_buck_mode; endproperty
   property p_cur;
      !$past(sys_rst) |-> cfg.prechg_ma inside {[10'd50:10'd800]} &&
         cfg.term_ma inside {[10'd50:10'd800]};
   endproperty
   property p_thermal_reg_threshold;
      !$past(sys_rst) |-> cfg.thermal_reg_threshold_c inside {8'd60, 8'd80, 8'd100, 8'd120};
   endproperty
   property p_exit; !$past(sys_rst) |-> cfg.exit_mv inside {13'd5600, 13'd6000}; endproperty
   property p_wd; watchdog_expired |=> !watchdog_expired; endproperty

   a_rsvd: assert property (p_rsvd) else $error("reserved bit read high");
   a_kick: assert property (p_kick) else $error("kick bit read high");
   a_current_limit_pin: assert property (p_current_limit_pin) else $error("input limit above pin");
   a_rbuck: assert property (p_rbuck) else $error("reverse buck while charging");
   a_cur: assert property (p_cur) else $error("current setting out of range");
   a_thermal_reg_threshold: assert property (p_thermal_reg_threshold) else $error("thermal threshold bad");
   a_exit: assert property (p_exit) else $error("exit threshold bad");
   a_wd: assert property (p_wd) else $error("expiry pulse too long");

   // Main scenarios reached
   c_wd: cover property (watchdog_expired);
   c_det: cover property (source_detect_start);
   c_opt: cover property (optimizer_force_start);
endmodule : ccr_properties

bind ccr_top ccr_properties i_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .current_limit_pin(current_limit_pin), .optimizer_force_start(optimizer_force_start),
   .watchdog_expired(watchdog_expired), .source_detect_start(source_detect_start),
   .cfg(cfg));

// ===== ccr_stmr.sv
`timescale 1ns/1ps
module ccr_stmr #(
   parameter int unsigned TICK_CYCLES = ccr_pkg::CLK_HZ
) (
   input  wire logic       clk_sys,   // System clock
   input  wire logic       sys_rst,   // Async reset, high
   input  wire logic       enable,    // Timer enabled and charging
   input  wire logic [1:0] hours_sel, // Fast charge limit code
   input  wire logic       restart,   // Restart counting
   input  wire logic       slow,      // Count at half speed
   output logic            expired    // Limit reached, level
);
   localparam int PW = (TICK_CYCLES < 2) ? 1 : $clog2(TICK_CYCLES);

   if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("ccr_stmr: TICK_CYCLES must be at least 2");
   end

   logic [PW-1:0]              pre_reg, pre_next;
   logic [ccr_pkg::SEC_W-1:0]  sec_reg, sec_next;
   logic                       ph_reg, ph_next;
   logic                       exp_reg, exp_next;
   logic                       advance;

   // Half speed skips every other prescaler step
   always_comb begin
      ph_next  = slow ? ~ph_reg : 1'b0;
      advance  = ~slow | ph_reg;
      pre_next = pre_reg;
      sec_next = sec_reg;
      exp_next = exp_reg;
      if (restart || !enable) begin
         pre_next = '0;
         sec_next = '0;
         exp_next = 1'b0;
      end else if (advance && !exp_reg) begin
         pre_next = pre_reg + PW'(1);
         if (pre_reg == PW'(TICK_CYCLES - 1)) begin
            pre_next = '0;
            sec_next = sec_reg + ccr_pkg::SEC_W'(1);
            if (sec_reg >= ccr_pkg::fct_seconds(hours_sel) - ccr_pkg::SEC_W'(1)) begin
               exp_next = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pre_reg <= '0;
         sec_reg <= '0;
         ph_reg  <= 1'b0;
         exp_reg <= 1'b0;
      end else begin
         pre_reg <= pre_next;
         sec_reg <= sec_next;
         ph_reg  <= ph_next;
         exp_reg <= exp_next;
      end
   end

   assign expired = exp_reg;
endmodule : ccr_stmr

// ===== ccr_top.sv
`timescale 1ns/1ps
module ccr_top #(
   parameter int unsigned TICK_CYCLES = ccr_pkg::CLK_HZ // Clock cycles per second
) (
   input  wire logic          clk_sys,           // System clock, 100 MHz
   input  wire logic          sys_rst,           // Async reset, high
   input  wire logic [7:0]    reg_addr,          // Register offset
   input  wire logic          reg_wr,            // Write strobe
   input  wire logic [7:0]    reg_wdata,         // Write data
   input  wire logic          reg_rd,            // Read strobe
   output logic [7:0]         reg_rdata,         // Read data, one cycle later
   input  wire logic          reg_reset_cmd,     // Register reset command pulse
   input  wire logic          optimizer_started, // Optimizer has begun
   input  wire logic          detect_done,       // Source detection finished
   input  wire logic          vbus_plug_in,      // Input power plug-in pulse
   input  wire logic [4:0]    current_limit_pin, // Limit code from the pin
   input  wire logic          input_power_limiting, // Input loop is limiting
   input  wire logic          thermal_regulation,   // Thermal loop is active
   input  wire logic          charging_active,   // Charger in fast charge
   output logic               optimizer_force_start, // Start pulse to optimizer
   output logic               source_detect_start,   // Start pulse to detector
   output logic               watchdog_expired,  // Watchdog expiry pulse
   output logic               safety_timer_expired, // Safety limit reached
   output ccr_pkg::ccr_cfg_t  cfg                // Decoded settings
);

   logic [7:0] icc_reg, icc_next;   // Input current control
   logic [7:0] ptc_reg, ptc_next;   // Precharge and termination
   logic [7:0] co1_reg, co1_next;   // Charger control one
   logic [7:0] co2_reg, co2_next;   // Charger control two
   logic       fos_reg, fos_next;   // Optimizer start pulse
   logic       sds_reg, sds_next;   // Detection start pulse
   logic [7:0] rd_reg,  rd_next;
   ccr_pkg::ccr_cfg_t cfg_reg, cfg_next;

   logic       wr_icc, wr_ptc, wr_co1, wr_co2, wr_kick;
   logic       wd_exp, wd_restart, fct_restart, fct_run;
   logic       force_set, det_set, opt_en_new;

   // Address decode of the write strobe
   always_comb begin
      wr_icc  = reg_wr && reg_addr == ccr_pkg::ADDR_INPUT_CURRENT;
      wr_ptc  = reg_wr && reg_addr == ccr_pkg::ADDR_PRECHG_TERM;
      wr_co1  = reg_wr && reg_addr == ccr_pkg::ADDR_CTRL_ONE;
      wr_co2  = reg_wr && reg_addr == ccr_pkg::ADDR_CTRL_TWO;
      wr_kick = reg_wr && reg_addr == ccr_pkg::ADDR_WD_KICK
                && reg_wdata[ccr_pkg::KICK_BIT];
   end

   // Register file next state; reset command beats expiry beats write
   always_comb begin
      icc_next   = icc_reg;
      ptc_next   = ptc_reg;
      co1_next   = co1_reg;
      co2_next   = co2_reg;
      opt_en_new = wr_icc ? reg_wdata[ccr_pkg::OPT_EN_BIT] : icc_reg[ccr_pkg::OPT_EN_BIT];
      // Force bit only takes a one, and only with the optimizer on
      force_set  = wr_icc && reg_wdata[ccr_pkg::FORCE_OPT_BIT] && opt_en_new;
      det_set    = wr_icc && reg_wdata[ccr_pkg::FORCE_DET_BIT];
      if (wr_icc) begin
         icc_next = reg_wdata;
      end
      // Hardware clears, but a set in the same cycle wins
      icc_next[ccr_pkg::FORCE_OPT_BIT] = force_set
         || (icc_reg[ccr_pkg::FORCE_OPT_BIT] && !optimizer_started);
      icc_next[ccr_pkg::FORCE_DET_BIT] = det_set
         || (icc_reg[ccr_pkg::FORCE_DET_BIT] && !detect_done);
      if (wr_ptc) begin
         ptc_next = reg_wdata;
      end
      if (wr_co1) begin
         co1_next = reg_wdata;
      end
      co1_next[ccr_pkg::RSVD_BIT] = 1'b0;
      if (wr_co2) begin
         co2_next = reg_wdata;
      end
      // Expiry restores only the fields that the masks name
      if (wd_exp) begin
         icc_next = (icc_next & ~ccr_pkg::WDM_INPUT_CURRENT)
                  | (ccr_pkg::RST_INPUT_CURRENT & ccr_pkg::WDM_INPUT_CURRENT);
         ptc_next = (ptc_next & ~ccr_pkg::WDM_PRECHG_TERM)
                  | (ccr_pkg::RST_PRECHG_TERM & ccr_pkg::WDM_PRECHG_TERM);
         co1_next = (co1_next & ~ccr_pkg::WDM_CTRL_ONE)
                  | (ccr_pkg::RST_CTRL_ONE & ccr_pkg::WDM_CTRL_ONE);
         co2_next = (co2_next & ~ccr_pkg::WDM_CTRL_TWO)
                  | (ccr_pkg::RST_CTRL_TWO & ccr_pkg::WDM_CTRL_TWO);
      end
      if (reg_reset_cmd) begin
         icc_next = ccr_pkg::RST_INPUT_CURRENT;
         ptc_next = ccr_pkg::RST_PRECHG_TERM;
         co1_next = ccr_pkg::RST_CTRL_ONE;
         co2_next = ccr_pkg::RST_CTRL_TWO;
      end
   end

   // Start pulses leave on the edge of a new request; detection also starts on a plug-in with auto detect on
   always_comb begin
      fos_next = icc_next[ccr_pkg::FORCE_OPT_BIT]
                 && !icc_reg[ccr_pkg::FORCE_OPT_BIT];
      sds_next = (icc_next[ccr_pkg::FORCE_DET_BIT] && !icc_reg[ccr_pkg::FORCE_DET_BIT])
                 || (vbus_plug_in && co2_reg[ccr_pkg::AUTO_DET_BIT]);
   end

   // Counter restarts follow real changes, so a rewrite of the same code is harmless
   always_comb begin
      wd_restart  = wr_kick
         || co1_next[ccr_pkg::WD_LSB +: ccr_pkg::SEL_W]
            != co1_reg[ccr_pkg::WD_LSB +: ccr_pkg::SEL_W];
      fct_restart = co1_next[ccr_pkg::FCT_LSB +: ccr_pkg::SEL_W]
                    != co1_reg[ccr_pkg::FCT_LSB +: ccr_pkg::SEL_W];
      fct_run     = co1_reg[ccr_pkg::TIMER_EN_BIT] && charging_active;
   end

   // Decoded settings; clamp both limits before taking the lower one
   always_comb begin
      logic [4:0] reg_code;
      logic [4:0] pin_code;
      logic [4:0] eff_code;
      reg_code = ccr_pkg::current_limit_pin_clamp(icc_reg[ccr_pkg::CURRENT_LIMIT_PIN_LSB +: ccr_pkg::CURRENT_LIMIT_PIN_W]);
      pin_code = ccr_pkg::current_limit_pin_clamp(current_limit_pin);
      eff_code = (pin_code < reg_code) ? pin_code : reg_code;
      cfg_next = '0;
      cfg_next.current_limit_pin_ma = 12'(ccr_pkg::CURRENT_LIMIT_PIN_OFFSET_MA
                         + ccr_pkg::CURRENT_LIMIT_PIN_STEP_MA * int'(eff_code));
      cfg_next.prechg_ma = 10'(ccr_pkg::CUR_OFFSET_MA + ccr_pkg::CUR_STEP_MA
                         * int'(ptc_reg[ccr_pkg::PRECHG_LSB +: ccr_pkg::CUR_W]));
      cfg_next.term_ma = 10'(ccr_pkg::CUR_OFFSET_MA + ccr_pkg::CUR_STEP_MA
                         * int'(ptc_reg[ccr_pkg::TERM_LSB +: ccr_pkg::CUR_W]));
      cfg_next.term_en   = co1_reg[ccr_pkg::TERM_EN_BIT];
      cfg_next.timer_en  = co1_reg[ccr_pkg::TIMER_EN_BIT];
      cfg_next.half_rate = co1_reg[ccr_pkg::HALF_BIT];
      case (co2_reg[ccr_pkg::THERMAL_REG_THRESHOLD_LSB +: ccr_pkg::SEL_W])
         2'h0:    cfg_next.thermal_reg_threshold_c = 8'(ccr_pkg::THERMAL_REG_THRESHOLD_00_C);
         2'h1:    cfg_next.thermal_reg_threshold_c = 8'(ccr_pkg::THERMAL_REG_THRESHOLD_01_C);
         2'h2:    cfg_next.thermal_reg_threshold_c = 8'(ccr_pkg::THERMAL_REG_THRESHOLD_10_C);
         default: cfg_next.thermal_reg_threshold_c = 8'(ccr_pkg::THERMAL_REG_THRESHOLD_11_C);
      endcase
      cfg_next.exit_mv = co2_reg[ccr_pkg::EXIT_BIT] ? 13'(ccr_pkg::EXIT_HIGH_MV)
                                                    : 13'(ccr_pkg::EXIT_LOW_MV);
      cfg_next.rechg_mv = 9'(ccr_pkg::RECHG_OFFSET_MV + ccr_pkg::RECHG_STEP_MV
                          * int'(co2_reg[ccr_pkg::RECHG_LSB +: ccr_pkg::SEL_W]));
      cfg_next.charge_mode = co2_reg[ccr_pkg::CHG_EN_BIT];
      cfg_next.reverse_buck_mode = co2_reg[ccr_pkg::REVB_BIT]
                                   && !co2_reg[ccr_pkg::CHG_EN_BIT];
      cfg_next.optimizer_en   = icc_reg[ccr_pkg::OPT_EN_BIT];
      cfg_next.auto_detect_en = co2_reg[ccr_pkg::AUTO_DET_BIT];
   end

   // Read mux; unmapped offsets and the kick offset read zero
   always_comb begin
      rd_next = rd_reg;
      if (reg_rd) begin
         case (reg_addr)
            ccr_pkg::ADDR_INPUT_CURRENT: rd_next = icc_reg;
            ccr_pkg::ADDR_PRECHG_TERM:   rd_next = ptc_reg;
            ccr_pkg::ADDR_CTRL_ONE:      rd_next = co1_reg;
            ccr_pkg::ADDR_CTRL_TWO:      rd_next = co2_reg;
            default:                     rd_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         icc_reg <= ccr_pkg::RST_INPUT_CURRENT;
         ptc_reg <= ccr_pkg::RST_PRECHG_TERM;
         co1_reg <= ccr_pkg::RST_CTRL_ONE;
         co2_reg <= ccr_pkg::RST_CTRL_TWO;
         fos_reg <= 1'b0;
         sds_reg <= 1'b0;
         rd_reg  <= 8'h00;
         cfg_reg <= '0;
      end else begin
         icc_reg <= icc_next;
         ptc_reg <= ptc_next;
         co1_reg <= co1_next;
         co2_reg <= co2_next;
         fos_reg <= fos_next;
         sds_reg <= sds_next;
         rd_reg  <= rd_next;
         cfg_reg <= cfg_next;
      end
   end

   // Watchdog; a kick is a pulse, so the kick bit never holds a one
   ccr_wdog #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_wdog (
      .clk_sys    (clk_sys),
      .sys_rst    (sys_rst),
      .period_sel (co1_reg[ccr_pkg::WD_LSB +: ccr_pkg::SEL_W]),
      .restart    (wd_restart),
      .expired    (wd_exp)
   );

   // Safety timer slows only while a loop is limiting
   ccr_stmr #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_stmr (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .enable    (fct_run),
      .hours_sel (co1_reg[ccr_pkg::FCT_LSB +: ccr_pkg::SEL_W]),
      .restart   (fct_restart),
      .slow      (co1_reg[ccr_pkg::HALF_BIT]
                  && (input_power_limiting || thermal_regulation)),
      .expired   (safety_timer_expired)
   );

   assign reg_rdata             = rd_reg;
   assign optimizer_force_start = fos_reg;
   assign source_detect_start   = sds_reg;
   assign watchdog_expired      = wd_exp;
   assign cfg                   = cfg_reg;

endmodule : ccr_top

// ===== ccr_wdog.sv
`timescale 1ns/1ps
module ccr_wdog #(
   parameter int unsigned TICK_CYCLES = ccr_pkg::CLK_HZ
) (
   input  wire logic       clk_sys,    // System clock
   input  wire logic       sys_rst,    // Async reset, high
   input  wire logic [1:0] period_sel, // Watchdog period code
   input  wire logic       restart,    // Restart counting
   output logic            expired     // Expiry pulse
);
   localparam int PW = (TICK_CYCLES < 2) ? 1 : $clog2(TICK_CYCLES);

   if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("ccr_wdog: TICK_CYCLES must be at least 2");
   end

   logic [PW-1:0] pre_reg, pre_next;
   logic [7:0]    sec_reg, sec_next;
   logic          exp_reg, exp_next;
   logic [7:0]    limit;

   // Seconds prescaler and period counter; code 00 parks it
   always_comb begin
      limit    = ccr_pkg::wd_seconds(period_sel);
      pre_next = pre_reg + PW'(1);
      sec_next = sec_reg;
      exp_next = 1'b0;
      if (restart || limit == 8'h00) begin
         pre_next = '0;
         sec_next = 8'h00;
      end else if (pre_reg == PW'(TICK_CYCLES - 1)) begin
         pre_next = '0;
         if (sec_reg >= limit - 8'h01) begin
            sec_next = 8'h00;
            exp_next = 1'b1;
         end else begin
            sec_next = sec_reg + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pre_reg <= '0;
         sec_reg <= 8'h00;
         exp_reg <= 1'b0;
      end else begin
         pre_reg <= pre_next;
         sec_reg <= sec_next;
         exp_reg <= exp_next;
      end
   end

   assign expired = exp_reg;
endmodule : ccr_wdog

// ===== tb_charger_config_registers.sv
`timescale 1ns/1ps
module tb_charger_config_registers;
   logic              clk_sys, sys_rst, reg_wr, reg_rd, reg_reset_cmd, optimizer_started;
   logic              detect_done, vbus_plug_in, input_power_limiting, thermal_regulation;
   logic              charging_active, optimizer_force_start, source_detect_start;
   logic              watchdog_expired, safety_timer_expired;
   logic [7:0]        reg_addr, reg_wdata, reg_rdata;
   logic [4:0]        current_limit_pin;
   ccr_pkg::ccr_cfg_t cfg;
   int                error_cnt, samples_checked, n_opt, n_det, n_wd, cyc, a, d, n0;
   int                m[4];
   int                seed = 32'h900e;
   int                rs[4] = '{8'h39, 8'h22, 8'h9d, 8'h7d};
   int                wm[4] = '{8'hc0, 8'hff, 8'hff, 8'hfc};

   // Watchdog second shortened to 10 cycles so 40 s is 400 cycles
   ccr_top #(.TICK_CYCLES(10)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_reset_cmd(reg_reset_cmd),
      .optimizer_started(optimizer_started), .detect_done(detect_done),
      .vbus_plug_in(vbus_plug_in), .current_limit_pin(current_limit_pin),
      .input_power_limiting(input_power_limiting), .thermal_regulation(thermal_regulation),
      .charging_active(charging_active), .optimizer_force_start(optimizer_force_start),
      .source_detect_start(source_detect_start), .watchdog_expired(watchdog_expired),
      .safety_timer_expired(safety_timer_expired), .cfg(cfg));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // Pulse counters; the cycle ceiling cuts a hang short
   always @(posedge clk_sys) begin
      n_opt += int'(optimizer_force_start === 1'b1);
      n_det += int'(source_detect_start === 1'b1);
      n_wd += int'(watchdog_expired === 1'b1);
      cyc++;
      if (cyc == 4000) begin
         error_cnt++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : stop_test

   task automatic chk(string s, logic [31:0] e, logic [31:0] g);
      samples_checked++;
      if (e !== g) begin
         error_cnt++;
         $display("BAD %s exp %0h got %0h", s, e, g);
      end
   endtask : chk

   task automatic chk_cfg(ccr_pkg::ccr_cfg_t e);
      samples_checked++;
      if (e !== cfg) begin
         error_cnt++;
         $display("BAD cfg exp %h got %h", e, cfg);
      end
   endtask : chk_cfg

   // Strobes rise and fall at falling edges, held across one rising edge
   task automatic wr(logic [7:0] ad, logic [7:0] dt);
      @(negedge clk_sys);
      reg_addr = ad;
      reg_wdata = dt;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask : wr

   task automatic rd(logic [7:0] ad, logic [31:0] e);
      @(negedge clk_sys);
      reg_addr = ad;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      chk("reg_rdata", e, {24'h0, reg_rdata});
   endtask : rd

   task automatic pls(ref logic s);
      @(negedge clk_sys);
      s = 1'b1;
      @(negedge clk_sys);
      s = 1'b0;
   endtask : pls

   // Reference decode; only the register code clamps at 1Ch, then the lower code wins
   function automatic ccr_pkg::ccr_cfg_t ecfg();
      ccr_pkg::ccr_cfg_t e;
      int                l, p;
      l = (m[0] & 31) > 28 ? 28 : m[0] & 31;
      p = int'(current_limit_pin);
      e.current_limit_pin_ma = 12'(500 + 100 * (p < l ? p : l));
      e.prechg_ma = 10'(50 + 50 * (m[1] >> 4));
      e.term_ma = 10'(50 + 50 * (m[1] & 15));
      e.term_en = m[2][7];
      e.timer_en = m[2][3];
      e.half_rate = m[2][0];
      e.thermal_reg_threshold_c = 8'(60 + 20 * ((m[3] >> 4) & 3));
      e.exit_mv = m[3][2] ? 13'd6000 : 13'd5600;
      e.rechg_mv = 9'(100 + 100 * (m[3] & 3));
      e.charge_mode = m[3][3];
      e.reverse_buck_mode = m[3][7] & ~m[3][3];
      e.optimizer_en = m[0][5];
      e.auto_detect_en = m[3][6];
      return e;
   endfunction : ecfg

   task automatic all_chk();
      for (int i = 0; i < 4; i++) rd(8'(i + 3), m[i]);
      chk_cfg(ecfg());
      chk("stmr_exp", 0, {31'h0, safety_timer_expired});
   endtask : all_chk

   // Expiry must land inside the window, then masked fields go default
   task automatic wd_wait(int lo, int hi);
      int c0;
      c0 = n_wd;
      d = 0;
      while (n_wd == c0 && d < 900) begin
         @(negedge clk_sys);
         d++;
      end
      chk("wd_in_window", 1, 32'(d >= lo && d <= hi));
      for (int i = 0; i < 4; i++) m[i] = (m[i] & ~wm[i]) | (rs[i] & wm[i]);
   endtask : wd_wait

   initial begin
      {reg_wr, reg_rd, reg_reset_cmd, optimizer_started, detect_done} = '0;
      {vbus_plug_in, input_power_limiting, thermal_regulation} = '0;
      charging_active = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      current_limit_pin = 5'h1f;
      m = rs;
      sys_rst = 1'b1;
      repeat (12) @(negedge clk_sys);
      sys_rst = 1'b0;
      all_chk();
      rd(8'h20, 0);
      $display("reset values done");
      // Random settings; the kick keeps the watchdog clear of the loop
      wr(8'h07, 8'h40);
      repeat (24) begin
         a = 3 + ($unsigned($random(seed)) % 4);
         d = $random(seed) & (a == 3 ? 8'h3f : 8'hff);
         current_limit_pin = 5'($random(seed));
         {input_power_limiting, thermal_regulation} = 2'($random(seed));
         wr(8'(a), 8'(d));
         m[a - 3] = a == 5 ? d & 8'hbf : d;
         repeat (2) @(negedge clk_sys);
         chk_cfg(ecfg());
         rd(8'(a), m[a - 3]);
      end
      $display("random settings done");
      wr(8'h05, 8'(m[2] & 8'hcf));
      m[2] = 8'h1a;
      wr(8'h05, 8'h1a);
      wd_wait(385, 410);
      all_chk();
      repeat (200) @(negedge clk_sys);
      wr(8'h05, 8'(m[2]));
      wd_wait(170, 205);
      repeat (200) @(negedge clk_sys);
      wr(8'h07, 8'h40);
      rd(8'h07, 0);
      wd_wait(380, 405);
      // Second period code, 80 s is 800 cycles
      m[2] = 8'had;
      wr(8'h05, 8'had);
      wd_wait(790, 810);
      $display("watchdog done");
      n0 = n_opt;
      wr(8'h03, 8'hb9);
      rd(8'h03, 8'hb9);
      pls(optimizer_started);
      rd(8'h03, 8'h39);
      wr(8'h03, 8'h99);
      rd(8'h03, 8'h19);
      chk("opt_pulses", n0 + 1, n_opt);
      n0 = n_det;
      wr(8'h03, 8'h59);
      rd(8'h03, 8'h59);
      pls(detect_done);
      rd(8'h03, 8'h19);
      pls(vbus_plug_in);
      m[0] = 8'h19;
      m[3] = m[3] & 8'hbf;
      wr(8'h06, 8'(m[3]));
      pls(vbus_plug_in);
      repeat (3) @(negedge clk_sys);
      chk("det_pulses", n0 + 2, n_det);
      wr(8'h20, 8'hff);
      all_chk();
      pls(reg_reset_cmd);
      m = rs;
      all_chk();
      $display("handshakes and reset done");
      stop_test();
   end
endmodule : tb_charger_config_registers
